// ==== src/mms_defs.vh ====
`ifndef MMS_DEFS_VH
`define MMS_DEFS_VH
// Width of the byte-wide address space per die plus two die bits
`define MMS_ADDR_W        23
`define MMS_DATA_W        8
// Position of the two upper address bits in shared-select mode
`define MMS_ADDR_TOP_BIT  22
`define MMS_ADDR_SEC_BIT  21
// Clock period in ns
`define MMS_CLK_NS        10
// Sleep entry pulse, least time in ns, rounded up to cycles
`define MMS_SLEEP_NS      50
`define MMS_SLEEP_CYC     ((`MMS_SLEEP_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
// Sleep exit wait in us, least time, rounded up to cycles
`define MMS_WAKE_US       100
`define MMS_WAKE_CYC      ((`MMS_WAKE_US * 1000 + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
// Read and write cycle time, 50 ns least
`define MMS_CYCLE_NS      50
`define MMS_CYCLE_CYC     ((`MMS_CYCLE_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
// Write pulse width, 28 ns least
`define MMS_WPULSE_NS     28
`define MMS_WPULSE_CYC    ((`MMS_WPULSE_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
// Write recovery, 16 ns least
`define MMS_WREC_NS       16
`define MMS_WREC_CYC      ((`MMS_WREC_NS + `MMS_CLK_NS - 1) / `MMS_CLK_NS)
// Shared select decode table for upper address bits
`define MMS_DIE_00        2'h0
`define MMS_DIE_01        2'h1
`define MMS_DIE_10        2'h3
`define MMS_DIE_11        2'h2
`endif

// ==== src/mms_die_sel.v ====
`default_nettype none
`include "mms_defs.vh"
// Builds the select pins for one access: either the shared select with the
// die coded in the two upper address bits, or one individual select.
module mms_die_sel (
  input  wire [1:0]                die,
  input  wire                      shared_mode,
  input  wire                      active,
  output reg                       sel_shared_n,
  output reg  [3:0]                sel_n,
  output reg  [1:0]                upper_bits
);
  // Inverse of the device decode: die number to upper address bits
  function [1:0] mms_die_to_bits;
    input [1:0] d;
    begin
      if (d == `MMS_DIE_00) begin
        mms_die_to_bits = 2'h0;
      end else if (d == `MMS_DIE_01) begin
        mms_die_to_bits = 2'h1;
      end else if (d == `MMS_DIE_10) begin
        mms_die_to_bits = 2'h2;
      end else begin
        mms_die_to_bits = 2'h3;
      end
    end
  endfunction

  always @* begin
    sel_shared_n = 1'b1;
    sel_n        = 4'hF;
    upper_bits   = 2'h0;
    if (shared_mode) begin
      // Individual selects stay high so the device decodes the address
      upper_bits = mms_die_to_bits(die); // [RULE10]
      if (active) begin
        sel_shared_n = 1'b0;
      end
    end else if (active) begin
      // One-hot low: never more than one individual select at once
      sel_n = ~(4'h1 << die); // [RULE9] [RULE11]
    end
  end
endmodule // mms_die_sel
`default_nettype wire

// ==== src/mms_host.v ====
`default_nettype none
`include "mms_defs.vh"
// How it works
// RULE1 - Address is valid no later than the select falling edge.
// RULE2 - Device writes only during overlap of select low and write enable low.
// RULE3 - Output enable falling at or after write enable keeps outputs floating.
// RULE4 - Select falling after or rising before write enable keeps outputs floating.
// RULE5 - Host holds write enable high during every read.
// RULE6 - Sleep-reset is held high at least 50 ns to enter sleep.
// RULE7 - Write enable and all selects are high when sleep-reset falls.
// RULE8 - Host waits 100 us after sleep-reset falls before any access.
// RULE9 - At most one individual die select is low at any time.
// RULE10 - Shared mode decodes upper bits 00,01,10,11 as die 0,1,3,2.
// RULE11 - Individual mode: select n enables die n, upper bits ignored.
// RULE12 - Device floats data when asleep, unselected or both strobes high.
module mms_host #(
  parameter WAKE_CYC = `MMS_WAKE_CYC
) (
  input  wire                      clock,
  input  wire                      rst_n,
  input  wire                      shared_mode,
  input  wire                      req_valid,
  output wire                      req_ready,
  input  wire                      req_write,
  input  wire [`MMS_ADDR_W-1:0]    req_addr,
  input  wire [`MMS_DATA_W-1:0]    req_wdata,
  output reg                       rsp_valid_r,
  output reg  [`MMS_DATA_W-1:0]    rsp_rdata_r,
  input  wire                      sleep_req,
  output wire                      asleep,
  output reg  [`MMS_ADDR_W-1:0]    mem_addr_r,
  output wire                      mem_sel_shared_n,
  output wire [3:0]                mem_sel_n,
  output reg                       mem_we_n_r,
  output reg                       mem_oe_n_r,
  output reg                       sleep_reset_r,
  input  wire [`MMS_DATA_W-1:0]    mem_dq_in,
  output reg  [`MMS_DATA_W-1:0]    mem_dq_out_r,
  output reg                       mem_dq_oe_r
);
  localparam [2:0] ST_WAKE  = 3'h0;
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_READ  = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_WREC  = 3'h4;
  localparam [2:0] ST_SLEEP = 3'h5;
  localparam [2:0] ST_SLHLD = 3'h6;

  // Kept as integers so the rounded-up counts are never cut before the compare
  localparam integer CYC_W = `MMS_CYCLE_CYC;
  localparam integer WP_W  = `MMS_WPULSE_CYC;
  localparam integer WR_W  = `MMS_WREC_CYC;
  localparam integer SL_W  = `MMS_SLEEP_CYC;
  localparam integer WK_W  = WAKE_CYC;

  reg  [2:0]                state_r;
  reg  [23:0]               cnt_r;
  reg  [1:0]                die_r;
  reg                       active_r;
  wire [1:0]                upper_bits;
  wire                      sel_shared_raw;
  wire [3:0]                sel_raw;

  mms_die_sel u_sel (
    .die          (die_r),
    .shared_mode  (shared_mode),
    .active       (active_r),
    .sel_shared_n (sel_shared_raw),
    .sel_n        (sel_raw),
    .upper_bits   (upper_bits)
  );

  // Selects forced high while sleep-reset is high or while waking
  assign mem_sel_shared_n = sel_shared_raw | ~active_r; // [RULE7]
  assign mem_sel_n        = sel_raw | {4{~active_r}};
  assign req_ready        = (state_r == ST_IDLE) && !sleep_req;
  assign asleep           = (state_r == ST_SLEEP) || (state_r == ST_SLHLD);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= ST_WAKE;
      cnt_r         <= 24'h0;
      die_r         <= 2'h0;
      active_r      <= 1'b0;
      mem_addr_r    <= {`MMS_ADDR_W{1'b0}};
      mem_we_n_r    <= 1'b1;
      mem_oe_n_r    <= 1'b1;
      sleep_reset_r <= 1'b0;
      mem_dq_out_r  <= {`MMS_DATA_W{1'b0}};
      mem_dq_oe_r   <= 1'b0;
      rsp_valid_r   <= 1'b0;
      rsp_rdata_r   <= {`MMS_DATA_W{1'b0}};
    end else begin
      rsp_valid_r <= 1'b0;
      case (state_r)
        ST_WAKE: begin
          // Treat reset as a fresh exit from sleep before first access
          if (cnt_r >= WK_W - 24'h1) begin // [RULE8]
            state_r <= ST_IDLE;
            cnt_r   <= 24'h0;
          end else begin
            cnt_r <= cnt_r + 24'h1;
          end
        end
        ST_IDLE: begin
          if (sleep_req) begin
            sleep_reset_r <= 1'b1;
            state_r       <= ST_SLHLD;
            cnt_r         <= 24'h0;
          end else if (req_valid) begin
            // Address and die settle in the same edge the select falls
            mem_addr_r <= req_addr; // [RULE1]
            if (shared_mode) begin
              mem_addr_r[`MMS_ADDR_TOP_BIT] <= upper_bits_of(req_addr);
              mem_addr_r[`MMS_ADDR_SEC_BIT] <= upper_sec_of(req_addr);
            end
            die_r    <= req_addr[`MMS_ADDR_TOP_BIT:`MMS_ADDR_SEC_BIT];
            active_r <= 1'b1;
            cnt_r    <= 24'h0;
            if (req_write) begin
              // Output enable stays high so the device never drives
              mem_we_n_r   <= 1'b0; // [RULE2] [RULE3] [RULE4]
              mem_oe_n_r   <= 1'b1;
              mem_dq_out_r <= req_wdata;
              mem_dq_oe_r  <= 1'b1;
              state_r      <= ST_WRITE;
            end else begin
              mem_we_n_r <= 1'b1; // [RULE5]
              mem_oe_n_r <= 1'b0;
              state_r    <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (cnt_r >= CYC_W - 24'h1) begin
            rsp_rdata_r <= mem_dq_in; // [RULE12]
            rsp_valid_r <= 1'b1;
            mem_oe_n_r  <= 1'b1;
            active_r    <= 1'b0;
            state_r     <= ST_IDLE;
            cnt_r       <= 24'h0;
          end else begin
            cnt_r <= cnt_r + 24'h1;
          end
        end
        ST_WRITE: begin
          // Write enable rises while select is still low: write ends on it
          if (cnt_r >= WP_W - 24'h1) begin
            mem_we_n_r <= 1'b1; // [RULE4]
            state_r    <= ST_WREC;
            cnt_r      <= 24'h0;
          end else begin
            cnt_r <= cnt_r + 24'h1;
          end
        end
        ST_WREC: begin
          // Data and address held through recovery, then select released
          if (cnt_r >= WR_W - 24'h1) begin
            active_r    <= 1'b0;
            mem_dq_oe_r <= 1'b0;
            rsp_valid_r <= 1'b1;
            state_r     <= ST_IDLE;
            cnt_r       <= 24'h0;
          end else begin
            cnt_r <= cnt_r + 24'h1;
          end
        end
        ST_SLHLD: begin
          if (cnt_r >= SL_W - 24'h1) begin // [RULE6]
            state_r <= ST_SLEEP;
          end else begin
            cnt_r <= cnt_r + 24'h1;
          end
        end
        ST_SLEEP: begin
          if (!sleep_req) begin
            // Strobes and selects are already high here
            sleep_reset_r <= 1'b0; // [RULE7]
            state_r       <= ST_WAKE;
            cnt_r         <= 24'h0;
          end
        end
        default: begin
          state_r <= ST_WAKE;
        end
      endcase
    end
  end

  // Die number to upper address bits under the shared select
  function upper_bits_of;
    input [`MMS_ADDR_W-1:0] a;
    reg   [1:0]             d;
    begin
      d = a[`MMS_ADDR_TOP_BIT:`MMS_ADDR_SEC_BIT];
      upper_bits_of = (d == `MMS_DIE_10) || (d == `MMS_DIE_11); // [RULE10]
    end
  endfunction

  function upper_sec_of;
    input [`MMS_ADDR_W-1:0] a;
    reg   [1:0]             d;
    begin
      d = a[`MMS_ADDR_TOP_BIT:`MMS_ADDR_SEC_BIT];
      upper_sec_of = (d == `MMS_DIE_01) || (d == `MMS_DIE_11);
    end
  endfunction
endmodule // mms_host
`default_nettype wire

// ==== sim/mms_host_assertions.sv ====
`default_nettype none
module mms_host_assertions #(
  parameter int WAKE_CYC = 20
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [22:0] mem_addr_r,
  input wire logic        mem_sel_shared_n,
  input wire logic [3:0]  mem_sel_n,
  input wire logic        mem_we_n_r,
  input wire logic        mem_oe_n_r,
  input wire logic        sleep_reset_r,
  input wire logic        mem_dq_oe_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic sel_any = !mem_sel_shared_n || mem_sel_n != 4'hF;
  int        wake_cnt_r;
  // Saturates, so a long idle stretch never wraps below the limit
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) wake_cnt_r <= 0;
    else wake_cnt_r <= sleep_reset_r ? 0 : wake_cnt_r + int'(wake_cnt_r < WAKE_CYC);
  sequence s_sleep_hold;
    sleep_reset_r [*5];
  endsequence
  a_addr_held: assert property (sel_any && $past(sel_any) |-> $stable(mem_addr_r))
    else $error("address moved under select");
  a_read_only: assert property (!mem_oe_n_r |-> mem_we_n_r && !mem_dq_oe_r)
    else $error("write or drive during read");
  a_sleep_pulse: assert property ($rose(sleep_reset_r) |-> s_sleep_hold)
    else $error("sleep pulse short");
  a_sleep_exit: assert property ($fell(sleep_reset_r) |-> mem_we_n_r && !sel_any)
    else $error("strobe low at sleep exit");
  a_wake_wait: assert property (sel_any |-> wake_cnt_r >= WAKE_CYC - 1)
    else $error("access before wake wait");
  a_one_die: assert property ($onehot0(~mem_sel_n))
    else $error("two selects low");
endmodule // mms_host_assertions
bind mms_host mms_host_assertions #(.WAKE_CYC(WAKE_CYC)) i_mms_host_assertions (
  .clock, .rst_n, .mem_addr_r, .mem_sel_shared_n, .mem_sel_n, .mem_we_n_r, .mem_oe_n_r,
  .sleep_reset_r, .mem_dq_oe_r);
`default_nettype wire

// ==== sim/mms_mem_model.sv ====
`default_nettype none
module mms_mem_model (
  input  wire logic        sleep_reset_r,
  input  wire logic        mem_sel_shared_n,
  input  wire logic [3:0]  mem_sel_n,
  input  wire logic [22:0] mem_addr_r,
  input  wire logic        mem_we_n_r,
  input  wire logic        mem_oe_n_r,
  input  wire logic [7:0]  mem_dq_out_r,
  input  wire logic        mem_dq_oe_r,
  output var  logic [7:0]  mem_dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_r [0:63];
  logic [7:0] last_r = 8'hFF;
  logic [1:0] die;
  logic       hit, drive;
  always_comb begin
    die = {mem_addr_r[22], ^mem_addr_r[22:21]};
    if (mem_sel_shared_n)
      for (int k = 0; k < 4; k++) if (!mem_sel_n[k]) die = 2'(k);
    hit = !sleep_reset_r && (!mem_sel_shared_n || mem_sel_n != 4'hF);
    drive = hit && !mem_oe_n_r && mem_we_n_r;
  end
  always @* if (hit && !mem_we_n_r) mem_r[{die, mem_addr_r[3:0]}] = mem_dq_in;
  // A released bus shows the inverse of its last level, never a held copy
  always @* begin
    if (mem_dq_oe_r) last_r = mem_dq_out_r;
    else if (drive) last_r = mem_r[{die, mem_addr_r[3:0]}];
    mem_dq_in = mem_dq_oe_r || drive ? last_r : ~last_r;
  end
endmodule // mms_mem_model
`default_nettype wire

// ==== sim/test_mms_host.sv ====
`default_nettype none
module test_mms_host;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WAKE = 20;
  logic        clock = 1'h0, rst_n = 1'h0, shared_mode = 1'h0, sleep_req = 1'h0;
  logic        req_valid = 1'h0, req_write = 1'h0, req_ready, rsp_valid_r, asleep;
  logic        mem_sel_shared_n, mem_we_n_r, mem_oe_n_r, sleep_reset_r, mem_dq_oe_r;
  logic [22:0] req_addr = 23'h0, mem_addr_r;
  logic [7:0]  req_wdata = 8'h0, rsp_rdata_r, mem_dq_out_r, mem_dq_in, q;
  logic [3:0]  mem_sel_n;
  int          num_errors = 0, checks = 0, n;
  mms_host #(.WAKE_CYC(WAKE)) i_mms_host (.clock, .rst_n, .shared_mode, .req_valid,
    .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid_r, .rsp_rdata_r, .sleep_req,
    .asleep, .mem_addr_r, .mem_sel_shared_n, .mem_sel_n, .mem_we_n_r, .mem_oe_n_r,
    .sleep_reset_r, .mem_dq_in, .mem_dq_out_r, .mem_dq_oe_r);
  mms_mem_model i_mms_mem_model (.sleep_reset_r, .mem_sel_shared_n, .mem_sel_n, .mem_addr_r,
    .mem_we_n_r, .mem_oe_n_r, .mem_dq_out_r, .mem_dq_oe_r, .mem_dq_in);
  task check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'h1) num_errors++;
    if (ok !== 1'h1) $display("FAIL %0t %s", $time, msg);
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task access(input logic wr, input logic [22:0] a, input logic [7:0] d);
    @(negedge clock);
    {req_valid, req_write, req_addr, req_wdata} = {1'h1, wr, a, d};
    for (n = 0; req_ready !== 1'h1 && n < 99; n++) @(negedge clock);
    @(negedge clock);
    req_valid = 1'h0;
    for (n = 0; rsp_valid_r !== 1'h1 && n < 20; n++) @(negedge clock);
    check(n < 20, "no answer");
    q = rsp_rdata_r;
  endtask
  // Bytes written in one select mode are read back in the other, four accesses later
  task t_dies;
    for (int i = 0; i < 16; i++) begin
      shared_mode = i[3] ^ i[2];
      access(!i[2], {i[1:0], 21'h5}, 8'h50 + 8'(i));
      if (!i[2]) check(i_mms_mem_model.mem_r[{i[1:0], 4'h5}] === 8'h50 + 8'(i), "die write");
      else check(q === 8'h50 + 8'(i - 4), "die read");
    end
  endtask
  task t_sleep;
    sleep_req = 1'h1;
    repeat (8) @(negedge clock);
    check(asleep === 1'h1 && req_ready === 1'h0, "sleep entry");
    sleep_req = 1'h0;
    for (n = 0; req_ready !== 1'h1 && n < 999; n++) @(negedge clock);
    check(n >= WAKE && n < 999, "wake wait after sleep");
  endtask
  initial forever #5 clock = ~clock;
  initial begin
    #50000 num_errors++;
    finish_test;
  end
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'h1;
    for (n = 0; req_ready !== 1'h1 && n < 999; n++) @(negedge clock);
    check(n == WAKE && asleep === 1'h0, "wake after reset");
    t_dies;
    t_sleep;
    finish_test;
  end
endmodule // test_mms_host
`default_nettype wire
